// ==== sba_segment_allocator.sv ====
// segment buffer allocator: command engine, segment tables, ram access check
// Behaviour
// - short buffer uses at most four segments, long at most sixteen.
// - acquisition size given in bytes, any value; start address returned.
// - at most 128 short, 64 long buffers; total never beyond 128 Kbytes.
// - long buffers start from 0c000000h, short buffers from 08000000h.
// - short start address carries tag in bits 24..18, offset zero.
// - long start address carries tag in bits 23..18, offset zero.
// - whole release by start address frees every segment of the buffer.
// - tail return frees from the given byte address to buffer end.
// - after reset nothing is allocated; ram access denied until acquired.
// - an invalid argument reports the invalid-command code in the result.
// - long acquire code 5000h, length 1..2048, argument bits 23..16 zero.
// - short acquire code 5006h, length 1..512.
// - result in bits 2..0, bit 29 completion, other bits zero.
// - long address: 00001b, 100b, tag bits 23..18, zeros below.
// - short address: 00001b, 00b, tag bits 24..18, zeros below.
// - release code 5001h; 11b means no buffer there, address returns zero.
// - return code 5002h; three-bit result incl. 011b undefined, 100b freed.
// - buffers are chains of 128-byte segments addressed continuously.
// - a write to unacquired ram raises the violation output.
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
module sba_segment_allocator
  import sba_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // dma command port
  input wire logic dmaReq,
  input wire logic [15:0] dmaCode,
  input wire logic [31:0] dmaArg1,
  input wire logic [31:0] dmaArg2,
  output logic dmaAck,
  output logic [2:0] dmaResult,
  output logic [31:0] dmaAddr,
  // buffer ram access check
  input wire logic ramValid,
  input wire logic ramWrite,
  input wire logic [31:0] ramAddr,
  output logic ramGrant,
  output logic ramWrViolation,
  // ecc control
  output logic eccEnable
);
  // ****************************************
  // reset, bus decode
  // ****************************************
  logic rstN;
  sba_rst_sync u_rst (.clock(clock), .resetn(resetn), .rstN(rstN));

  logic [31:0] commandCode, firstArg, secondArg, resultWord, retAddr;
  logic cpuPend, lastCpu, cCpu;
  logic [15:0] cCode;
  logic [31:0] cA1, cA2;
  sba_state_t state;
  logic [2:0] shortCnt [SHORT_TAGS];
  logic [4:0] longCnt [LONG_TAGS];
  logic [10:0] freeSegs;

  wire busFirst = (read | write) & waitrequest;
  wire busTake = (read | write) & ~waitrequest;
  wire wrCmd = busTake & write & (address == OFF_CMD);
  wire wrArg1 = busTake & write & (address == OFF_ARG1);
  wire wrArg2 = busTake & write & (address == OFF_ARG2);
  wire wrEdc = busTake & write & (address == OFF_EDC);
  logic [31:0] rdMux;
  always_comb begin
    if (address == OFF_CMD) rdMux = commandCode;
    else if (address == OFF_ARG1) rdMux = firstArg;
    else if (address == OFF_ARG2) rdMux = secondArg;
    else if (address == OFF_RESULT) rdMux = resultWord;
    else if (address == OFF_RETADDR) rdMux = retAddr;
    else if (address == OFF_EDC) rdMux = {31'h0, eccEnable};
    else rdMux = 32'h0;
  end

  // ****************************************
  // occupancy and free-tag search
  // ****************************************
  logic [SHORT_TAGS-1:0] shortBusy;
  logic [LONG_TAGS-1:0] longBusy;
  for (genvar g = 0; g < SHORT_TAGS; g++) begin : g_sb
    assign shortBusy[g] = (shortCnt[g] != 3'h0);
  end
  for (genvar g = 0; g < LONG_TAGS; g++) begin : g_lb
    assign longBusy[g] = (longCnt[g] != 5'h0);
  end
  logic shortFound, longFound;
  logic [6:0] shortIdx;
  logic [5:0] longIdx;
  sba_find_free #(.N(SHORT_TAGS), .W(7)) u_sfree (
    .busy(shortBusy), .found(shortFound), .idx(shortIdx));
  sba_find_free #(.N(LONG_TAGS), .W(6)) u_lfree (
    .busy(longBusy), .found(longFound), .idx(longIdx));

  // ****************************************
  // arbitration
  // ****************************************
  wire dmaWant = dmaReq & ~dmaAck;
  wire pickCpu = (state == ST_IDLE) & cpuPend & (~dmaWant | ~lastCpu);
  wire pickDma = (state == ST_IDLE) & dmaWant & ~pickCpu;

  // ****************************************
  // command evaluation
  // ****************************************
  wire sba_region_t rg1 = sba_region(cA1);
  wire [6:0] tg1 = sba_tag(cA1, rg1);
  wire [4:0] cnt1 = (rg1 == REG_LONG) ? longCnt[tg1[5:0]] : {2'h0, shortCnt[tg1]};
  wire [15:0] len = cA1[15:0];
  wire [16:0] lenSum = {1'b0, len} + SEG_ROUND;
  wire [4:0] need = lenSum[11:7];
  wire [17:0] off = cA2[17:0];
  wire [18:0] offSum = {1'b0, off} + {2'h0, SEG_ROUND};
  wire [4:0] keep = offSum[11:7];
  wire offPast = {1'b0, off} >= {7'h0, cnt1, 7'h0};

  logic [2:0] eRes;
  logic [31:0] eAddr;
  logic tWr, tLong;
  logic [6:0] tTag;
  logic [4:0] tCnt;
  logic [10:0] next_freeSegs;
  always_comb begin
    eRes = RES_INVALID;
    eAddr = 32'h0;
    tWr = 1'b0;
    tLong = 1'b0;
    tTag = tg1;
    tCnt = 5'h0;
    next_freeSegs = freeSegs;
    case (cCode)
      CMD_ACQ_LARGE: begin
        if (len == 16'h0 || len > LONG_MAX_LEN || cA1[23:16] != 8'h0) begin
          eRes = RES_INVALID;
        end else if (!longFound || {6'h0, need} > freeSegs) begin
          eRes = RES_NOBUF;
        end else begin
          eRes = RES_OK;
          eAddr = {ADDR_TOP, LONG_SEL, longIdx, 18'h0};
          tWr = 1'b1;
          tLong = 1'b1;
          tTag = {1'b0, longIdx};
          tCnt = need;
          next_freeSegs = freeSegs - {6'h0, need};
        end
      end
      CMD_ACQ_SMALL: begin
        if (len == 16'h0 || len > SHORT_MAX_LEN) begin
          eRes = RES_INVALID;
        end else if (!shortFound || {6'h0, need} > freeSegs) begin
          eRes = RES_NOBUF;
        end else begin
          eRes = RES_OK;
          eAddr = {ADDR_TOP, SHORT_SEL, shortIdx, 18'h0};
          tWr = 1'b1;
          tTag = shortIdx;
          tCnt = need;
          next_freeSegs = freeSegs - {6'h0, need};
        end
      end
      CMD_FREE_WHOLE: begin
        if (rg1 == REG_NONE) begin
          eRes = RES_INVALID;
        end else if (cnt1 == 5'h0 || cA1[17:0] != 18'h0) begin
          eRes = RES_NOBUF;
        end else begin
          eRes = RES_OK;
          tWr = 1'b1;
          tLong = (rg1 == REG_LONG);
          next_freeSegs = freeSegs + {6'h0, cnt1};
        end
      end
      CMD_FREE_TAIL: begin
        if (rg1 == REG_NONE || cA2[31:18] != cA1[31:18]) begin
          eRes = RES_INVALID;
        end else if (cnt1 == 5'h0 || cA1[17:0] != 18'h0) begin
          eRes = RES_NOBUF;
        end else if (offPast) begin
          eRes = RES_FREED;
        end else begin
          eRes = RES_OK;
          tWr = 1'b1;
          tLong = (rg1 == REG_LONG);
          tCnt = keep;
          next_freeSegs = freeSegs + {6'h0, cnt1 - keep};
        end
      end
      default: eRes = RES_INVALID;
    endcase
  end

  // ****************************************
  // engine and tables
  // ****************************************
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state <= ST_IDLE;
      cCpu <= 1'b0;
      lastCpu <= 1'b0;
      cCode <= 16'h0;
      cA1 <= 32'h0;
      cA2 <= 32'h0;
    end else if (state == ST_EXEC) begin
      state <= ST_IDLE;
    end else if (pickCpu || pickDma) begin
      state <= ST_EXEC;
      cCpu <= pickCpu;
      lastCpu <= pickCpu;
      cCode <= pickCpu ? commandCode[15:0] : dmaCode;
      cA1 <= pickCpu ? firstArg : dmaArg1;
      cA2 <= pickCpu ? secondArg : dmaArg2;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < SHORT_TAGS; i++) shortCnt[i] <= 3'h0;
      for (int i = 0; i < LONG_TAGS; i++) longCnt[i] <= 5'h0;
      freeSegs <= FREE_SEGS_RESET;
    end else if (state == ST_EXEC && tWr) begin
      if (tLong) longCnt[tTag[5:0]] <= tCnt;
      else shortCnt[tTag] <= tCnt[2:0];
      freeSegs <= next_freeSegs;
    end
  end

  // ****************************************
  // register file and dma answer
  // ****************************************
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
      commandCode <= 32'h0;
      firstArg <= 32'h0;
      secondArg <= 32'h0;
      eccEnable <= EDC_RESET;
    end else begin
      waitrequest <= ~busFirst;
      if (busFirst) readdata <= rdMux;
      if (wrCmd) commandCode <= {16'h0, writedata[15:0]};
      if (wrArg1) firstArg <= sba_lane(firstArg, writedata, byteenable);
      if (wrArg2) secondArg <= sba_lane(secondArg, writedata, byteenable);
      if (wrEdc && byteenable[0]) eccEnable <= writedata[EDC_ENABLE_BIT];
    end
  end

  wire cpuDone = (state == ST_EXEC) & cCpu;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      cpuPend <= 1'b0;
      resultWord <= 32'h0;
      retAddr <= 32'h0;
    end else begin
      if (wrCmd) cpuPend <= 1'b1;
      else if (pickCpu) cpuPend <= 1'b0;
      if (wrCmd) resultWord <= 32'h0;
      else if (cpuDone) resultWord <= {2'h0, 1'b1, 26'h0, eRes};
      if (cpuDone) retAddr <= eAddr;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      dmaAck <= 1'b0;
      dmaResult <= 3'h0;
      dmaAddr <= 32'h0;
    end else begin
      dmaAck <= (state == ST_EXEC) & ~cCpu;
      if ((state == ST_EXEC) && !cCpu) begin
        dmaResult <= eRes;
        dmaAddr <= eAddr;
      end
    end
  end

  // ****************************************
  // ram access check
  // ****************************************
  wire sba_region_t rgR = sba_region(ramAddr);
  wire [6:0] tgR = sba_tag(ramAddr, rgR);
  wire [4:0] cntR = (rgR == REG_LONG) ? longCnt[tgR[5:0]] : {2'h0, shortCnt[tgR]};
  wire ramHit = (rgR != REG_NONE) && ({6'h0, cntR} > ramAddr[17:7]);
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ramGrant <= 1'b0;
      ramWrViolation <= 1'b0;
    end else begin
      ramGrant <= ramValid & ramHit;
      ramWrViolation <= ramValid & ramWrite & ~ramHit;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);
  wire [31:0] gotAddr = cCpu ? retAddr : dmaAddr;
  wire [2:0] gotRes = cCpu ? resultWord[2:0] : dmaResult;
  sequence s_exec(logic [15:0] code);
    state == ST_EXEC && cCode == code;
  endsequence
  sequence s_grant(logic [15:0] code);
    s_exec(code) ##0 eRes == RES_OK;
  endsequence

  a_short_addr: assert property (s_grant(CMD_ACQ_SMALL) |=>
    gotAddr[31:25] == 7'h04 && gotAddr[17:0] == 18'h0 && gotRes == RES_OK)
    else $error("short start address malformed");
  a_long_addr: assert property (s_grant(CMD_ACQ_LARGE) |=>
    gotAddr[31:24] == 8'h0c && gotAddr[17:0] == 18'h0)
    else $error("long start address malformed");
  a_short_len: assert property (s_exec(CMD_ACQ_SMALL) ##0 len > SHORT_MAX_LEN |=>
    gotRes == RES_INVALID) else $error("oversize short not refused");
  a_long_len: assert property (s_exec(CMD_ACQ_LARGE) ##0 cA1[23:16] != 8'h0 |=>
    gotRes == RES_INVALID) else $error("reserved long bits not refused");
  a_seg_limit: assert property (s_grant(CMD_ACQ_SMALL) |-> need <= 5'(SHORT_MAX_SEGS))
    else $error("short buffer over four segments");
  a_ram_total: assert property (freeSegs <= FREE_SEGS_RESET)
    else $error("free segment count beyond ram size");
  a_reset_empty: assert property ($rose(rstN) |-> freeSegs == FREE_SEGS_RESET)
    else $error("ram allocated after reset");
  a_ram_deny: assert property (ramValid && !ramHit |=> !ramGrant)
    else $error("access granted to unacquired ram");
  a_wr_violation: assert property (ramValid && ramWrite && !ramHit |=> ramWrViolation)
    else $error("unacquired write not flagged");
  a_done_flag: assert property (cpuDone && !wrCmd |=>
    resultWord[DONE_BIT] && resultWord[31:3] == 29'h04000000)
    else $error("completion word malformed");
  a_release_free: assert property (s_grant(CMD_FREE_WHOLE) |=>
    freeSegs == $past(freeSegs) + {6'h0, $past(cnt1)})
    else $error("release did not free all segments");
  a_release_miss: assert property (s_exec(CMD_FREE_WHOLE) ##0 eRes == RES_NOBUF |=>
    gotAddr == 32'h0) else $error("failed release returned address");
endmodule : sba_segment_allocator

// ==== sba_pkg.sv ====
// shared constants, types and address helpers for the segment buffer allocator
package sba_pkg;
  // ****************************************
  // buffer geometry
  // ****************************************
  localparam int SEG_SHIFT = 7;
  localparam int RAM_SEGS = 1024;
  localparam int SHORT_TAGS = 128;
  localparam int LONG_TAGS = 64;
  localparam int SHORT_MAX_SEGS = 4;
  localparam int LONG_MAX_SEGS = 16;
  localparam logic [15:0] SHORT_MAX_LEN = 16'h0200;
  localparam logic [15:0] LONG_MAX_LEN = 16'h0800;
  localparam logic [16:0] SEG_ROUND = 17'h0007f;
  localparam logic [10:0] FREE_SEGS_RESET = 11'h400;
  // ****************************************
  // command codes and results
  // ****************************************
  localparam logic [15:0] CMD_ACQ_LARGE = 16'h5000;
  localparam logic [15:0] CMD_FREE_WHOLE = 16'h5001;
  localparam logic [15:0] CMD_FREE_TAIL = 16'h5002;
  localparam logic [15:0] CMD_ACQ_SMALL = 16'h5006;
  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_INVALID = 3'h2;
  localparam logic [2:0] RES_NOBUF = 3'h3;
  localparam logic [2:0] RES_FREED = 3'h4;
  localparam int DONE_BIT = 29;
  // ****************************************
  // logical address layout
  // ****************************************
  localparam logic [4:0] ADDR_TOP = 5'h01;
  localparam logic [2:0] LONG_SEL = 3'h4;
  localparam logic [1:0] SHORT_SEL = 2'h0;
  localparam int TAG_LO = 18;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_ARG1 = 5'h04;
  localparam logic [4:0] OFF_ARG2 = 5'h08;
  localparam logic [4:0] OFF_RESULT = 5'h0c;
  localparam logic [4:0] OFF_RETADDR = 5'h10;
  localparam logic [4:0] OFF_EDC = 5'h14;
  localparam int EDC_ENABLE_BIT = 0;
  localparam logic EDC_RESET = 1'b0;

  typedef enum logic [1:0] {REG_NONE, REG_SHORT, REG_LONG} sba_region_t;
  typedef enum logic {ST_IDLE, ST_EXEC} sba_state_t;

  function automatic sba_region_t sba_region(input logic [31:0] a);
    if (a[31:27] != ADDR_TOP) return REG_NONE;
    else if (a[26:24] == LONG_SEL) return REG_LONG;
    else if (a[26:25] == SHORT_SEL) return REG_SHORT;
    else return REG_NONE;
  endfunction : sba_region

  function automatic logic [6:0] sba_tag(input logic [31:0] a, input sba_region_t r);
    if (r == REG_LONG) return {1'b0, a[TAG_LO+5:TAG_LO]};
    else return a[TAG_LO+6:TAG_LO];
  endfunction : sba_tag

  function automatic logic [31:0] sba_lane(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (be[i]) r[8*i+:8] = d[8*i+:8];
    return r;
  endfunction : sba_lane
endpackage : sba_pkg

// ==== sba_rst_sync.sv ====
// two-stage release synchroniser for the asynchronous reset
`timescale 1ns/100ps
module sba_rst_sync (
  // clock and raw reset
  input wire logic clock,
  input wire logic resetn,
  // synchronised reset
  output logic rstN
);
  logic stage1;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      rstN <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      rstN <= stage1;
    end
  end
endmodule : sba_rst_sync

// ==== sba_find_free.sv ====
// lowest free identifier finder
`timescale 1ns/100ps
module sba_find_free #(
  parameter int N = 128,
  parameter int W = 7
) (
  // occupancy
  input wire logic [N-1:0] busy,
  // lowest free entry
  output logic found,
  output logic [W-1:0] idx
);
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        found = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule : sba_find_free

// ==== sba_dma_model.sv ====
// dma requester model driving the allocator's command port
`timescale 1ns/100ps
module sba_dma_model (
  // clock and answer
  input wire logic clock,
  input wire logic dmaAck,
  input wire logic [2:0] dmaResult,
  input wire logic [31:0] dmaAddr,
  // request
  output logic dmaReq,
  output logic [15:0] dmaCode,
  output logic [31:0] dmaArg1,
  output logic [31:0] dmaArg2
);
  // ****************************************
  // one command per call, held until ack
  // ****************************************
  initial begin
    dmaReq = 1'b0;
    dmaCode = 16'h0;
    dmaArg1 = 32'h0;
    dmaArg2 = 32'h0;
  end

  task automatic run(input logic [15:0] c, input logic [31:0] a1, input logic [31:0] a2,
                     input int lag, output logic [2:0] res, output logic [31:0] addr);
    int n;
    n = 0;
    res = 3'hx;
    addr = 32'hx;
    repeat (lag) @(posedge clock);
    dmaReq <= 1'b1;
    dmaCode <= c;
    dmaArg1 <= a1;
    dmaArg2 <= a2;
    while (n < 100) begin
      @(posedge clock);
      n++;
      if (dmaAck === 1'b1) begin
        res = dmaResult;
        addr = dmaAddr;
        n = 100;
      end
    end
    // release at the edge that saw the ack
    dmaReq <= 1'b0;
    // released lines show garbage, not the old command
    dmaCode <= ~c;
    dmaArg1 <= ~a1;
    dmaArg2 <= ~a2;
  endtask : run
endmodule : sba_dma_model

// ==== test_sba_segment_allocator.sv ====
// self-checking bench for the segment buffer allocator
`timescale 1ns/100ps
module test_sba_segment_allocator
  import sba_pkg::*;
;
  typedef struct packed {
    logic [15:0] c;
    logic [31:0] a1;
    logic [31:0] a2;
    logic [2:0] res;
    logic [31:0] adr;
  } sba_row_t;
  localparam logic [31:0] DONE_W = 32'h2000_0000;
  localparam sba_row_t ROWS [17] = '{
    '{CMD_ACQ_SMALL, 32'h64, 32'h0, RES_OK, 32'h0800_0000},
    '{CMD_ACQ_LARGE, 32'h800, 32'h0, RES_OK, 32'h0c00_0000},
    '{CMD_ACQ_SMALL, 32'h200, 32'h0, RES_OK, 32'h0804_0000},
    '{CMD_ACQ_SMALL, 32'h0, 32'h0, RES_INVALID, 32'h0},
    '{CMD_ACQ_SMALL, 32'h201, 32'h0, RES_INVALID, 32'h0},
    '{CMD_ACQ_LARGE, 32'h801, 32'h0, RES_INVALID, 32'h0},
    '{CMD_ACQ_LARGE, 32'h1_0001, 32'h0, RES_INVALID, 32'h0},
    '{CMD_FREE_WHOLE, 32'h0800_0000, 32'h0, RES_OK, 32'h0},
    '{CMD_FREE_WHOLE, 32'h0800_0000, 32'h0, RES_NOBUF, 32'h0},
    '{CMD_FREE_WHOLE, 32'h0c00_0080, 32'h0, RES_NOBUF, 32'h0},
    '{CMD_FREE_WHOLE, 32'h1000_0000, 32'h0, RES_INVALID, 32'h0},
    '{CMD_FREE_TAIL, 32'h0c00_0000, 32'h0c00_0100, RES_OK, 32'h0},
    '{CMD_FREE_TAIL, 32'h0c00_0000, 32'h0c00_0200, RES_FREED, 32'h0},
    '{CMD_FREE_TAIL, 32'h0c04_0000, 32'h0c04_0010, RES_NOBUF, 32'h0},
    '{CMD_FREE_TAIL, 32'h0c00_0000, 32'h0804_0000, RES_INVALID, 32'h0},
    '{16'h5555, 32'h0, 32'h0, RES_INVALID, 32'h0},
    '{CMD_ACQ_SMALL, 32'h1, 32'h0, RES_OK, 32'h0800_0000}};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] address = 5'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic dmaReq;
  logic [15:0] dmaCode;
  logic [31:0] dmaArg1;
  logic [31:0] dmaArg2;
  logic dmaAck;
  logic [2:0] dmaResult;
  logic [31:0] dmaAddr;
  logic ramValid = 1'b0;
  logic ramWrite = 1'b0;
  logic [31:0] ramAddr = 32'h0;
  logic ramGrant;
  logic ramWrViolation;
  logic eccEnable;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;

  sba_segment_allocator i_dut (.clock(clock), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .dmaReq(dmaReq), .dmaCode(dmaCode), .dmaArg1(dmaArg1),
    .dmaArg2(dmaArg2), .dmaAck(dmaAck), .dmaResult(dmaResult), .dmaAddr(dmaAddr),
    .ramValid(ramValid), .ramWrite(ramWrite), .ramAddr(ramAddr), .ramGrant(ramGrant),
    .ramWrViolation(ramWrViolation), .eccEnable(eccEnable));
  sba_dma_model i_dma (.clock(clock), .dmaAck(dmaAck), .dmaResult(dmaResult),
    .dmaAddr(dmaAddr), .dmaReq(dmaReq), .dmaCode(dmaCode), .dmaArg1(dmaArg1),
    .dmaArg2(dmaArg2));

  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_fail++;
      finish_test();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    q = 32'hx;
    @(posedge clock);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    while (n < 20) begin
      @(posedge clock);
      n++;
      if (waitrequest === 1'b0) begin
        q = readdata;
        n = 21;
      end
    end
    // bus timeout counts as a mismatch
    if (n == 20) n_fail++;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus_xfer

  task automatic cpu_cmd(input logic [15:0] c, input logic [31:0] a1, input logic [31:0] a2,
                         output logic [31:0] res, output logic [31:0] addr);
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h0;
    bus_xfer(1'b1, OFF_ARG1, a1, 4'hf, addr);
    bus_xfer(1'b1, OFF_ARG2, a2, 4'hf, addr);
    bus_xfer(1'b1, OFF_CMD, {16'h0, c}, 4'hf, addr);
    while (r[DONE_BIT] !== 1'b1 && n < 50) begin
      bus_xfer(1'b0, OFF_RESULT, 32'h0, 4'hf, r);
      n++;
    end
    res = r;
    bus_xfer(1'b0, OFF_RETADDR, 32'h0, 4'hf, addr);
  endtask : cpu_cmd

  task automatic ram_check(input logic [31:0] a, input logic wr, input logic g, input logic v);
    @(posedge clock);
    ramValid <= 1'b1;
    ramWrite <= wr;
    ramAddr <= a;
    @(posedge clock);
    ramValid <= 1'b0;
    ramAddr <= ~a;
    @(negedge clock);
    check_word({30'h0, ramGrant, ramWrViolation}, {30'h0, g, v});
  endtask : ram_check

  // acquire n buffers, touch each, overflow once, then free them all
  task automatic fill(input logic [15:0] c, input logic [31:0] len, input int n,
                      input logic [31:0] base, input logic [31:0] last);
    logic [31:0] r;
    logic [31:0] a;
    logic [31:0] e;
    for (int i = 0; i < n; i++) begin
      e = base | (32'(i) << TAG_LO);
      cpu_cmd(c, len, 32'h0, r, a);
      check_word(r, DONE_W | RES_OK);
      check_word(a, e);
      ram_check(e + last, 1'b1, 1'b1, 1'b0);
    end
    cpu_cmd(CMD_ACQ_SMALL, 32'h1, 32'h0, r, a);
    check_word(r, DONE_W | RES_NOBUF);
    for (int i = 0; i < n; i++) begin
      cpu_cmd(CMD_FREE_WHOLE, base | (32'(i) << TAG_LO), 32'h0, r, a);
      check_word(r, DONE_W | RES_OK);
      check_word(a, 32'h0);
    end
    ram_check(base + last, 1'b0, 1'b0, 1'b0);
  endtask : fill

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic [31:0] a;
    logic [31:0] b;
    logic [2:0] dr;
    logic [31:0] da;
    @(negedge clock);
    check_word({29'h0, waitrequest, dmaAck, eccEnable}, 32'h4);
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    bus_xfer(1'b0, OFF_RESULT, 32'h0, 4'hf, r);
    check_word(r, 32'h0);
    bus_xfer(1'b0, OFF_EDC, 32'h0, 4'hf, r);
    check_word(r, 32'h0);
    ram_check(32'h0800_0000, 1'b0, 1'b0, 1'b0);
    ram_check(32'h0c00_0000, 1'b1, 1'b0, 1'b1);
    fill(CMD_ACQ_LARGE, 32'h800, 64, 32'h0c00_0000, 32'h780);
    bus_xfer(1'b1, OFF_EDC, 32'h1, 4'h1, r);
    bus_xfer(1'b0, OFF_EDC, 32'h0, 4'hf, r);
    check_word({r[30:0], eccEnable}, 32'h3);
    fill(CMD_ACQ_SMALL, 32'h1, 128, 32'h0800_0000, 32'h0);
    for (int i = 0; i < 17; i++) begin
      cpu_cmd(ROWS[i].c, ROWS[i].a1, ROWS[i].a2, r, a);
      check_word(r, DONE_W | ROWS[i].res);
      check_word(a, ROWS[i].adr);
    end
    // ****************************************
    // awkward cases
    // ****************************************
    ram_check(32'h0c00_0080, 1'b0, 1'b1, 1'b0);
    ram_check(32'h0c00_0100, 1'b1, 1'b0, 1'b1);
    ram_check(32'h0804_0180, 1'b1, 1'b1, 1'b0);
    ram_check(32'h0804_0200, 1'b0, 1'b0, 1'b0);
    bus_xfer(1'b1, OFF_ARG1, 32'hffff_ffff, 4'hf, r);
    bus_xfer(1'b1, OFF_ARG1, 32'h0000_0064, 4'h3, r);
    bus_xfer(1'b0, OFF_ARG1, 32'h0, 4'hf, r);
    check_word(r, 32'hffff_0064);
    bus_xfer(1'b1, 5'h18, 32'h1234_5678, 4'hf, r);
    bus_xfer(1'b0, 5'h18, 32'h0, 4'hf, r);
    check_word(r, 32'h0);
    fork
      cpu_cmd(CMD_ACQ_SMALL, 32'ha, 32'h0, r, a);
      i_dma.run(CMD_ACQ_SMALL, 32'ha, 32'h0, 1, dr, da);
    join
    b = 32'h0808_0000 ^ 32'h080c_0000;
    check_word({31'h0, (a ^ da) === b && a[31:19] === 13'h0101}, 32'h1);
    check_word(r, DONE_W | RES_OK);
    check_word({29'h0, dr}, {29'h0, RES_OK});
    i_dma.run(CMD_FREE_WHOLE, da, 32'h0, 1, dr, b);
    check_word({dr, b[28:0]}, {RES_OK, 29'h0});
    i_dma.run(CMD_FREE_WHOLE, da, 32'h0, 2, dr, b);
    check_word({29'h0, dr}, {29'h0, RES_NOBUF});
    i_dma.run(CMD_FREE_TAIL, 32'h0804_0000, 32'h0804_0080, 4, dr, b);
    check_word({29'h0, dr}, {29'h0, RES_OK});
    ram_check(32'h0804_0080, 1'b0, 1'b0, 1'b0);
    ram_check(32'h0804_0000, 1'b1, 1'b1, 1'b0);
    // mid-run reset drops every held buffer
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    check_word({29'h0, waitrequest, eccEnable, ramGrant}, 32'h4);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    ram_check(32'h0804_0000, 1'b1, 1'b0, 1'b1);
    finish_test();
  end
endmodule : test_sba_segment_allocator
